// File: rtl/asp_pkg.sv
// Package with register map, field layout and reset values of the post-processor
package asp_pkg;
  localparam int ASP_DATA_W = 32;
  localparam int ASP_ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] ASP_OFS_MODE = 8'h00;
  localparam logic [7:0] ASP_OFS_AVG = 8'h04;
  localparam logic [7:0] ASP_OFS_OFFSET0 = 8'h08;
  localparam logic [7:0] ASP_OFS_OFFSET1 = 8'h0C;
  localparam logic [7:0] ASP_OFS_GAIN0 = 8'h10;
  localparam logic [7:0] ASP_OFS_GAIN1 = 8'h14;
  localparam logic [7:0] ASP_OFS_PATTERN = 8'h18;
  localparam logic [7:0] ASP_OFS_STATUS = 8'h1C;
  // Field positions and widths
  localparam int ASP_FMT_W = 3;
  localparam int ASP_EXP_W = 5;
  localparam int ASP_CODE_W = 24;
  localparam int ASP_GAIN_W = 16;
  localparam int ASP_CM_W = 8;
  localparam int ASP_AVG_W = 30;
  localparam int ASP_FRAC_BITS = 6;
  localparam int ASP_OR_BIT = 30;
  localparam int ASP_SYNC_BIT = 31;
  localparam int ASP_EXP_MAX = 16;
  // Output formats
  localparam logic [2:0] ASP_FMT_PLAIN24 = 3'h0;
  localparam logic [2:0] ASP_FMT_CM16 = 3'h1;
  localparam logic [2:0] ASP_FMT_CM24 = 3'h2;
  localparam logic [2:0] ASP_FMT_AVG = 3'h3;
  localparam logic [2:0] ASP_FMT_PATTERN = 3'h4;
  // Reset values
  localparam logic [2:0] ASP_RST_FMT = 3'h0;
  localparam logic [4:0] ASP_RST_EXP = 5'h00;
  localparam logic [23:0] ASP_RST_OFFSET = 24'h000000;
  localparam logic [15:0] ASP_RST_GAIN = 16'h8000;
  localparam logic [31:0] ASP_RST_PATTERN = 32'h5A5A0F0F;
  localparam int ASP_GAIN_SHIFT = 15;
  localparam logic [1:0] ASP_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASP_RESP_SLVERR = 2'h2;
endpackage

// File: rtl/asp_channel.sv
// One channel: offset, gain, clamping, boxcar_filter and output formatting
`timescale 1ns/1ps
module asp_channel #(
  parameter int ACC_W = 41
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sample in
  input wire logic conv_valid,
  input wire logic [asp_pkg::ASP_CODE_W-1:0] raw_code,
  input wire logic raw_sat,
  input wire logic [asp_pkg::ASP_CM_W-1:0] cm_code,
  // Settings
  input wire logic [2:0] output_format_select,
  input wire logic [4:0] block_length_exponent,
  input wire logic [asp_pkg::ASP_CODE_W-1:0] offset,
  input wire logic [asp_pkg::ASP_GAIN_W-1:0] channel_gain_factor,
  input wire logic [31:0] pattern,
  // Sample out
  output logic out_valid,
  output logic [31:0] out_word,
  output logic clamp_seen
);
  import asp_pkg::*;

  if (ACC_W < ASP_CODE_W + ASP_EXP_MAX + 1) begin : g_acc_check
    $error("ACC_W too small");
  end

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [15:0] cnt;
    logic ovr;
    logic valid;
    logic [31:0] word;
    logic clamp;
  } asp_chan_type;

  asp_chan_type ch_ff;
  asp_chan_type nxt_ch;

  logic signed [25:0] sum_ofs;
  logic signed [42:0] prod;
  logic signed [27:0] scaled;
  logic signed [23:0] adj;
  logic sat;
  logic avg_on;
  logic [15:0] last_cnt;
  logic signed [ACC_W-1:0] acc_sum;
  logic signed [ACC_W-1:0] avg_full;
  logic signed [ASP_AVG_W-1:0] avg30;

  always_comb begin
    sum_ofs = 26'(signed'(raw_code)) + 26'(signed'(offset));
    prod = 43'(sum_ofs) * 43'(signed'({1'b0, channel_gain_factor}));
    scaled = 28'(prod >>> ASP_GAIN_SHIFT);
    // Clamp to 24-bit range
    if (scaled > 28'sh07FFFFF) begin
      adj = 24'sh7FFFFF;
    end else if (scaled < -28'sh0800000) begin
      adj = 24'sh800000;
    end else begin
      adj = scaled[23:0];
    end
    sat = raw_sat | (scaled > 28'sh07FFFFF) | (scaled < -28'sh0800000);
    avg_on = (output_format_select == ASP_FMT_AVG) &&
      (block_length_exponent >= 5'd1) &&
      (block_length_exponent <= 5'(ASP_EXP_MAX));
    last_cnt = 16'((32'd1 << block_length_exponent) - 32'd1);
    acc_sum = ch_ff.acc + ACC_W'(adj);
    // Divide by 2^(N-6); multiply when N < 6
    if (block_length_exponent >= 5'(ASP_FRAC_BITS)) begin
      avg_full = acc_sum >>> (block_length_exponent - 5'(ASP_FRAC_BITS));
    end else begin
      avg_full = acc_sum <<< (5'(ASP_FRAC_BITS) - block_length_exponent);
    end
    avg30 = avg_full[ASP_AVG_W-1:0];
    nxt_ch = ch_ff;
    nxt_ch.valid = 1'b0;
    nxt_ch.clamp = 1'b0;
    if (!avg_on) begin
      nxt_ch.acc = '0;
      nxt_ch.cnt = '0;
      nxt_ch.ovr = 1'b0;
    end
    if (conv_valid) begin
      nxt_ch.valid = 1'b1;
      nxt_ch.clamp = sat;
      unique case (output_format_select)
        ASP_FMT_CM16: nxt_ch.word = {8'h00, adj[23:8], cm_code};
        ASP_FMT_CM24: nxt_ch.word = {adj, cm_code};
        ASP_FMT_AVG: begin
          if (avg_on) begin
            if (ch_ff.cnt == last_cnt) begin
              // Block done: emit average, clear accumulator
              nxt_ch.word = {1'b1, ch_ff.ovr | sat, avg30};
              nxt_ch.acc = '0;
              nxt_ch.cnt = '0;
              nxt_ch.ovr = 1'b0;
            end else begin
              nxt_ch.word[ASP_SYNC_BIT] = 1'b0;
              nxt_ch.acc = acc_sum;
              nxt_ch.cnt = ch_ff.cnt + 16'd1;
              nxt_ch.ovr = ch_ff.ovr | sat;
            end
          end else begin
            nxt_ch.word = {8'h00, adj};
          end
        end
        ASP_FMT_PATTERN: nxt_ch.word = pattern;
        default: nxt_ch.word = {8'h00, adj};
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_ff <= '0;
    end else begin
      ch_ff <= nxt_ch;
    end
  end

  assign out_valid = ch_ff.valid;
  assign out_word = ch_ff.word;
  assign clamp_seen = ch_ff.clamp;

  property p_pattern_out;
    @(posedge aclk) disable iff (!aresetn)
      conv_valid && output_format_select == ASP_FMT_PATTERN |=>
        out_valid && out_word == $past(pattern);
  endproperty
  a_pattern_out: assert property (p_pattern_out)
    else $error("pattern not output");

  property p_clamp_range;
    @(posedge aclk) disable iff (!aresetn)
      conv_valid && output_format_select == ASP_FMT_PLAIN24 |=>
        out_word[31:24] == 8'h00;
  endproperty
  a_clamp_range: assert property (p_clamp_range)
    else $error("plain word has upper bits set");

  property p_sync_block;
    @(posedge aclk) disable iff (!aresetn)
      conv_valid && avg_on && ch_ff.cnt != last_cnt |=>
        !out_word[ASP_SYNC_BIT];
  endproperty
  a_sync_block: assert property (p_sync_block)
    else $error("sync high mid block");

  property p_block_clear;
    @(posedge aclk) disable iff (!aresetn)
      conv_valid && avg_on && ch_ff.cnt == last_cnt |=>
        ch_ff.acc == '0 && ch_ff.cnt == 16'd0 && out_word[ASP_SYNC_BIT];
  endproperty
  a_block_clear: assert property (p_block_clear)
    else $error("accumulator not cleared at block end");

  property p_ovr_flag;
    @(posedge aclk) disable iff (!aresetn)
      conv_valid && avg_on && ch_ff.cnt == last_cnt && ch_ff.ovr |=>
        out_word[ASP_OR_BIT];
  endproperty
  a_ovr_flag: assert property (p_ovr_flag)
    else $error("overrange flag lost");

  property p_no_avg_idle;
    @(posedge aclk) disable iff (!aresetn)
      !avg_on |=> ch_ff.cnt == 16'd0;
  endproperty
  a_no_avg_idle: assert property (p_no_avg_idle)
    else $error("counting outside averaging mode");
endmodule

// File: rtl/asp_top.sv
// Dual-channel sample post-processor with AXI4-Lite register access
//
// Notes on behaviour
// - Average blocks of 2^N samples per channel, N from 1 to 16.
// - Clear the accumulator after each complete block; blocks share no samples.
// - Averaging only when format is 0x3 and exponent is 1 to 16.
// - Averaged word is 32 bits; lower 30 bits carry the block average.
// - Constant input gives a 30-bit average whose top 24 bits equal it.
// - Bit 30 flags any saturated sample within the block.
// - Bit 31 is high once per 2^N conversions, marking a new average.
// - Averages appear at the trigger rate divided by 2^N.
// - Block length exponent resets to zero, meaning no averaging.
// - Each channel adds its own 24-bit signed offset, reset zero.
// - Each channel scales by its 16-bit gain over 0x8000.
// - Gain resets to 0x8000, unity.
// - Offset and gain results saturate instead of wrapping.
// - Host-written 32-bit pattern goes out on both channels per conversion.
// - Format 0x4 selects the test pattern.
// - Test pattern resets to 0x5A5A0F0F.
// - One format setting governs both channels.
// - Adjusted 24-bit result clamps to 0x7FFFFF and 0x800000.
// - Formats 0x1 and 0x2 append an unadjusted 8-bit common-mode code.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module asp_top #(
  parameter int ACC_W = 41
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [asp_pkg::ASP_ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [asp_pkg::ASP_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [asp_pkg::ASP_ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [asp_pkg::ASP_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Conversion core
  input wire logic conversion_trigger,
  input wire logic [asp_pkg::ASP_CODE_W-1:0] ch0_code,
  input wire logic [asp_pkg::ASP_CODE_W-1:0] ch1_code,
  input wire logic ch0_sat,
  input wire logic ch1_sat,
  input wire logic [asp_pkg::ASP_CM_W-1:0] ch0_cm,
  input wire logic [asp_pkg::ASP_CM_W-1:0] ch1_cm,
  // Output register
  output logic sample_valid,
  output logic [31:0] ch0_word,
  output logic [31:0] ch1_word
);
  import asp_pkg::*;

  if (ACC_W < ASP_CODE_W + ASP_EXP_MAX + 1) begin : g_acc_check
    $error("ACC_W too small for the longest block");
  end

  typedef struct packed {
    logic [2:0] fmt;
    logic [4:0] exp;
    logic [23:0] ofs0;
    logic [23:0] ofs1;
    logic [15:0] gain0;
    logic [15:0] gain1;
    logic [31:0] pat;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] clamp_sticky;
  } asp_top_type;

  asp_top_type r_ff;
  asp_top_type nxt_r;

  logic v0;
  logic v1;
  logic c0;
  logic c1;
  logic do_write;
  logic do_read;
  logic [31:0] wmask;
  logic [31:0] wval;

  function automatic logic [31:0] asp_merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [31:0] m);
    asp_merge = (old_v & ~m) | (new_v & m);
  endfunction

  always_comb begin
    nxt_r = r_ff;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{r_ff.w_strb[i]}};
    end
    wval = r_ff.w_data;
    do_write = r_ff.aw_got && r_ff.w_got && !r_ff.bvalid;
    do_read = s_axi_arvalid && !r_ff.rvalid;
    if (s_axi_awvalid && !r_ff.aw_got) begin
      nxt_r.aw_got = 1'b1;
      nxt_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_ff.w_got) begin
      nxt_r.w_got = 1'b1;
      nxt_r.w_data = s_axi_wdata;
      nxt_r.w_strb = s_axi_wstrb;
    end
    // Hardware set wins over software clear
    nxt_r.clamp_sticky = r_ff.clamp_sticky;
    if (do_write) begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = ASP_RESP_OKAY;
      unique case ({r_ff.aw_addr[7:2], 2'b00})
        ASP_OFS_MODE: nxt_r.fmt = 3'(asp_merge(32'(r_ff.fmt), wval, wmask));
        ASP_OFS_AVG: nxt_r.exp = 5'(asp_merge(32'(r_ff.exp), wval, wmask));
        ASP_OFS_OFFSET0:
          nxt_r.ofs0 = 24'(asp_merge(32'(r_ff.ofs0), wval, wmask));
        ASP_OFS_OFFSET1:
          nxt_r.ofs1 = 24'(asp_merge(32'(r_ff.ofs1), wval, wmask));
        ASP_OFS_GAIN0:
          nxt_r.gain0 = 16'(asp_merge(32'(r_ff.gain0), wval, wmask));
        ASP_OFS_GAIN1:
          nxt_r.gain1 = 16'(asp_merge(32'(r_ff.gain1), wval, wmask));
        ASP_OFS_PATTERN: nxt_r.pat = asp_merge(r_ff.pat, wval, wmask);
        ASP_OFS_STATUS: nxt_r.clamp_sticky = r_ff.clamp_sticky &
          ~(wval[1:0] & wmask[1:0]);
        default: nxt_r.bresp = ASP_RESP_SLVERR;
      endcase
    end
    nxt_r.clamp_sticky = nxt_r.clamp_sticky | {c1, c0};
    if (r_ff.bvalid && s_axi_bready) begin
      nxt_r.bvalid = 1'b0;
    end
    if (r_ff.rvalid && s_axi_rready) begin
      nxt_r.rvalid = 1'b0;
    end
    if (do_read) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = ASP_RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        ASP_OFS_MODE: nxt_r.rdata = 32'(r_ff.fmt);
        ASP_OFS_AVG: nxt_r.rdata = 32'(r_ff.exp);
        ASP_OFS_OFFSET0: nxt_r.rdata = 32'(r_ff.ofs0);
        ASP_OFS_OFFSET1: nxt_r.rdata = 32'(r_ff.ofs1);
        ASP_OFS_GAIN0: nxt_r.rdata = 32'(r_ff.gain0);
        ASP_OFS_GAIN1: nxt_r.rdata = 32'(r_ff.gain1);
        ASP_OFS_PATTERN: nxt_r.rdata = r_ff.pat;
        ASP_OFS_STATUS: nxt_r.rdata = 32'(r_ff.clamp_sticky);
        default: begin
          nxt_r.rdata = 32'h00000000;
          nxt_r.rresp = ASP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_ff <= '0;
      r_ff.fmt <= ASP_RST_FMT;
      r_ff.exp <= ASP_RST_EXP;
      r_ff.ofs0 <= ASP_RST_OFFSET;
      r_ff.ofs1 <= ASP_RST_OFFSET;
      r_ff.gain0 <= ASP_RST_GAIN;
      r_ff.gain1 <= ASP_RST_GAIN;
      r_ff.pat <= ASP_RST_PATTERN;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign s_axi_awready = !r_ff.aw_got;
  assign s_axi_wready = !r_ff.w_got;
  assign s_axi_bvalid = r_ff.bvalid;
  assign s_axi_bresp = r_ff.bresp;
  assign s_axi_arready = !r_ff.rvalid;
  assign s_axi_rvalid = r_ff.rvalid;
  assign s_axi_rdata = r_ff.rdata;
  assign s_axi_rresp = r_ff.rresp;

  // Both channels share one format and exponent
  asp_channel #(.ACC_W(ACC_W)) u_ch0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .conv_valid(conversion_trigger),
    .raw_code(ch0_code),
    .raw_sat(ch0_sat),
    .cm_code(ch0_cm),
    .output_format_select(r_ff.fmt),
    .block_length_exponent(r_ff.exp),
    .offset(r_ff.ofs0),
    .channel_gain_factor(r_ff.gain0),
    .pattern(r_ff.pat),
    .out_valid(v0),
    .out_word(ch0_word),
    .clamp_seen(c0)
  );

  asp_channel #(.ACC_W(ACC_W)) u_ch1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .conv_valid(conversion_trigger),
    .raw_code(ch1_code),
    .raw_sat(ch1_sat),
    .cm_code(ch1_cm),
    .output_format_select(r_ff.fmt),
    .block_length_exponent(r_ff.exp),
    .offset(r_ff.ofs1),
    .channel_gain_factor(r_ff.gain1),
    .pattern(r_ff.pat),
    .out_valid(v1),
    .out_word(ch1_word),
    .clamp_seen(c1)
  );

  assign sample_valid = v0 & v1;

  property p_same_pattern;
    @(posedge aclk) disable iff (!aresetn)
      conversion_trigger && r_ff.fmt == ASP_FMT_PATTERN |=>
        ch0_word == ch1_word;
  endproperty
  a_same_pattern: assert property (p_same_pattern)
    else $error("channels differ in pattern mode");

  property p_bresp_follows;
    @(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid;
  endproperty
  a_bresp_follows: assert property (p_bresp_follows)
    else $error("write response missing");

  property p_sticky_set;
    @(posedge aclk) disable iff (!aresetn)
      c0 |=> r_ff.clamp_sticky[0];
  endproperty
  a_sticky_set: assert property (p_sticky_set)
    else $error("clamp event lost");

  property p_sticky_set1;
    @(posedge aclk) disable iff (!aresetn)
      c1 |=>
        r_ff.clamp_sticky[1];
  endproperty
  a_sticky_set1: assert property (p_sticky_set1)
    else $error("channel 1 clamp event lost");

  property p_cfg_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |->
        r_ff.fmt == ASP_RST_FMT && r_ff.exp == ASP_RST_EXP;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("format or exponent not at reset value");

  property p_gain_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |->
        r_ff.gain0 == ASP_RST_GAIN && r_ff.gain1 == ASP_RST_GAIN;
  endproperty
  a_gain_reset: assert property (p_gain_reset)
    else $error("gain not at unity after reset");

  property p_pattern_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |->
        r_ff.pat == ASP_RST_PATTERN && r_ff.ofs0 == ASP_RST_OFFSET;
  endproperty
  a_pattern_reset: assert property (p_pattern_reset)
    else $error("pattern or offset not at reset value");

  property p_offset_write;
    @(posedge aclk) disable iff (!aresetn)
      do_write && r_ff.aw_addr == ASP_OFS_OFFSET0 && (&r_ff.w_strb) |=>
        r_ff.ofs0 == $past(r_ff.w_data[23:0]);
  endproperty
  a_offset_write: assert property (p_offset_write)
    else $error("offset write lost");

  property p_gain_write;
    @(posedge aclk) disable iff (!aresetn)
      do_write && r_ff.aw_addr == ASP_OFS_GAIN1 && (&r_ff.w_strb) |=>
        r_ff.gain1 == $past(r_ff.w_data[15:0]);
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain write lost");

  property p_pattern_write;
    @(posedge aclk) disable iff (!aresetn)
      do_write && r_ff.aw_addr == ASP_OFS_PATTERN && (&r_ff.w_strb) |=>
        r_ff.pat == $past(r_ff.w_data);
  endproperty
  a_pattern_write: assert property (p_pattern_write)
    else $error("pattern write lost");

  property p_mode_write;
    @(posedge aclk) disable iff (!aresetn)
      do_write && r_ff.aw_addr == ASP_OFS_MODE && r_ff.w_strb[0] |=>
        r_ff.fmt == $past(r_ff.w_data[2:0]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("format write lost");

  property p_sample_timing;
    @(posedge aclk) disable iff (!aresetn)
      conversion_trigger |=>
        sample_valid;
  endproperty
  a_sample_timing: assert property (p_sample_timing)
    else $error("no sample after trigger");

  property p_read_pattern;
    @(posedge aclk) disable iff (!aresetn)
      do_read && s_axi_araddr == ASP_OFS_PATTERN |=>
        s_axi_rvalid && s_axi_rdata == $past(r_ff.pat);
  endproperty
  a_read_pattern: assert property (p_read_pattern)
    else $error("pattern read back wrong");

  property p_unmapped_write;
    @(posedge aclk) disable iff (!aresetn)
      do_write && r_ff.aw_addr > ASP_OFS_STATUS + 8'h03 |=>
        s_axi_bresp == ASP_RESP_SLVERR;
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write not refused");
endmodule

// File: verification/asp_host_model.sv
// Host-side model that captures every output sample pair
`timescale 1ns/1ps
module asp_host_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Output register of the device
  input wire logic sample_valid,
  input wire logic [31:0] ch0_word,
  input wire logic [31:0] ch1_word,
  // Captured sample
  output logic cap_stb_ff,
  output logic [31:0] cap0_ff,
  output logic [31:0] cap1_ff
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_stb_ff <= 1'b0;
      cap0_ff <= 32'h00000000;
      cap1_ff <= 32'h00000000;
    end else begin
      cap_stb_ff <= sample_valid;
      if (sample_valid) begin
        cap0_ff <= ch0_word;
        cap1_ff <= ch1_word;
      end
    end
  end
endmodule

// File: verification/adc_sample_postprocessing_tb.sv
// Self-checking bench for the sample post-processor
`timescale 1ns/1ps
module adc_sample_postprocessing_tb;
  import asp_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, trig, s0, s1, sv, cstb;
  logic [7:0] awaddr, araddr, cm0, cm1;
  logic [31:0] wdata, rdata, w0, w1, c0, c1;
  logic [1:0] bresp, rresp;
  logic [23:0] d0, d1;
  logic [2:0] fmt;
  int nexp, failures, checks_done;
  logic [23:0] off[2];
  logic [15:0] gn[2];
  logic [31:0] pat;
  longint acc[2];
  int cnt[2];
  bit orf[2];
  bit [1:0] stk;
  logic [31:0] q0[$], q1[$], qm[$];

  always #2.5 aclk = ~aclk;

  asp_top dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .conversion_trigger(trig),
    .ch0_code(d0), .ch1_code(d1), .ch0_sat(s0), .ch1_sat(s1),
    .ch0_cm(cm0), .ch1_cm(cm1), .sample_valid(sv), .ch0_word(w0),
    .ch1_word(w1));

  asp_host_model host_u (.aclk(aclk), .aresetn(aresetn),
    .sample_valid(sv), .ch0_word(w0), .ch1_word(w1), .cap_stb_ff(cstb),
    .cap0_ff(c0), .cap1_ff(c1));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) chk(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 0;
    d = 32'h0;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) chk(32'h0, 32'h1);
  endtask

  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, ASP_RESP_OKAY});
    case (a)
      ASP_OFS_MODE: fmt = d[2:0];
      ASP_OFS_AVG: nexp = int'(d[4:0]);
      ASP_OFS_OFFSET0: off[0] = d[23:0];
      ASP_OFS_OFFSET1: off[1] = d[23:0];
      ASP_OFS_GAIN0: gn[0] = d[15:0];
      ASP_OFS_GAIN1: gn[1] = d[15:0];
      ASP_OFS_PATTERN: pat = d;
      default: ;
    endcase
    if (!(fmt == ASP_FMT_AVG && nexp >= 1 && nexp <= 16)) begin
      acc = '{0, 0};
      cnt = '{0, 0};
      orf = '{0, 0};
    end
  endtask

  function automatic logic [31:0] calc(input int ch, input logic [23:0] c,
      input logic st, input logic [7:0] cm, output logic [31:0] m);
    longint s;
    logic cl;
    logic [23:0] a;
    logic [31:0] w;
    s = ((longint'($signed(c)) + longint'($signed(off[ch])))
        * longint'(gn[ch])) >>> 15;
    cl = (s > 8388607) || (s < -8388608);
    stk[ch] |= st | cl;
    a = (s > 8388607) ? 24'h7FFFFF : (s < -8388608) ? 24'h800000 : s[23:0];
    m = 32'hFFFFFFFF;
    w = {8'h00, a};
    if (fmt == ASP_FMT_AVG && nexp >= 1 && nexp <= 16) begin
      acc[ch] += longint'($signed(a));
      orf[ch] |= st | cl;
      cnt[ch]++;
      m = 32'h80000000;
      w = 32'h0;
      if (cnt[ch] == (1 << nexp)) begin
        s = (nexp >= 6) ? acc[ch] >>> (nexp - 6) : acc[ch] <<< (6 - nexp);
        w = {1'b1, orf[ch], s[29:0]};
        m = 32'hFFFFFFFF;
        acc[ch] = 0;
        cnt[ch] = 0;
        orf[ch] = 0;
      end
    end else if (fmt == ASP_FMT_PATTERN) begin
      w = pat;
    end else if (fmt == ASP_FMT_CM16) begin
      w = {8'h00, a[23:8], cm};
    end else if (fmt == ASP_FMT_CM24) begin
      w = {a, cm};
    end
    return w;
  endfunction

  task automatic run(input int n, input bit fix);
    logic [23:0] k0, k1;
    logic t0, t1;
    logic [7:0] m0, m1;
    logic [31:0] mk;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      k0 = fix ? 24'h812345 : 24'($urandom);
      k1 = fix ? 24'h3C0FFE : 24'($urandom);
      t0 = ($urandom_range(15) == 0);
      t1 = ($urandom_range(15) == 0);
      m0 = 8'($urandom);
      m1 = 8'($urandom);
      q0.push_back(calc(0, k0, t0, m0, mk));
      q1.push_back(calc(1, k1, t1, m1, mk));
      qm.push_back(mk);
      trig <= 1'b1;
      d0 <= k0;
      d1 <= k1;
      s0 <= t0;
      s1 <= t1;
      cm0 <= m0;
      cm1 <= m1;
    end
    @(posedge aclk);
    trig <= 1'b0;
    for (int g = 0; g < 20 && q0.size() > 0; g++) @(posedge aclk);
    if (q0.size() > 0) chk(32'h0, 32'h1);
  endtask

  always @(posedge aclk) begin
    logic [31:0] m;
    if (cstb === 1'b1) begin
      if (q0.size() == 0) begin
        chk(32'h0, 32'h1);
      end else begin
        m = qm.pop_front();
        chk(c0 & m, q0.pop_front() & m);
        chk(c1 & m, q1.pop_front() & m);
      end
    end
  end

  initial begin
    repeat (80000) @(posedge aclk);
    chk(32'h0, 32'h1);
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] rst_tab[8];
    rst_tab = '{0, 0, 0, 0, 32'h8000, 32'h8000, 32'h5A5A0F0F, 0};
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, trig, s0, s1} = 8'h00;
    {awaddr, araddr, cm0, cm1, wdata, d0, d1} = 112'h0;
    fmt = 3'h0;
    nexp = 0;
    off = '{24'h000000, 24'h000000};
    gn = '{16'h8000, 16'h8000};
    pat = 32'h5A5A0F0F;
    void'($urandom(32'h92324079));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4), d, r);
      chk(d, rst_tab[i]);
    end
    rd(8'h20, d, r);
    chk({d[29:0], r}, {30'h0, ASP_RESP_SLVERR});
    wr(8'h24, 32'h1, r);
    chk({30'h0, r}, {30'h0, ASP_RESP_SLVERR});
    run(5, 0);
    for (int f = 0; f < 3; f++) begin
      cfg(ASP_OFS_MODE, 32'(f));
      for (int j = 0; j < 3; j++) begin
        cfg(ASP_OFS_OFFSET0, j == 0 ? 32'h007FFFFF : $urandom);
        cfg(ASP_OFS_OFFSET1, j == 1 ? 32'h00800000 : $urandom);
        cfg(ASP_OFS_GAIN0, j == 2 ? 32'h0000FFFF : $urandom_range(65535));
        cfg(ASP_OFS_GAIN1, j == 0 ? 32'h0 : $urandom_range(65535));
        run(20, 0);
      end
    end
    rd(ASP_OFS_STATUS, d, r);
    chk(d, {30'h0, stk});
    cfg(ASP_OFS_STATUS, 32'h3);
    stk = 2'h0;
    rd(ASP_OFS_STATUS, d, r);
    chk(d, 32'h0);
    cfg(ASP_OFS_MODE, 32'h5);
    run(4, 0);
    cfg(ASP_OFS_PATTERN, $urandom);
    cfg(ASP_OFS_MODE, 32'(ASP_FMT_PATTERN));
    run(6, 0);
    cfg(ASP_OFS_MODE, 32'(ASP_FMT_AVG));
    cfg(ASP_OFS_AVG, 32'h0);
    run(6, 0);
    cfg(ASP_OFS_AVG, 32'h11);
    run(6, 0);
    cfg(ASP_OFS_OFFSET0, 32'h0);
    cfg(ASP_OFS_GAIN0, 32'h8000);
    cfg(ASP_OFS_OFFSET1, 32'h400000);
    cfg(ASP_OFS_GAIN1, 32'hC000);
    foreach (rst_tab[i]) begin
      rst_tab[i] = 32'h0;
    end
    for (int k = 0; k < 6; k++) begin
      nexp = (k == 5) ? 16 : (k == 4) ? 7 : k + 1;
      cfg(ASP_OFS_MODE, 32'h0);
      cfg(ASP_OFS_AVG, 32'(nexp));
      cfg(ASP_OFS_MODE, 32'(ASP_FMT_AVG));
      run(nexp == 16 ? 65537 : 3 * (1 << nexp) + 1, k == 2);
    end
    stop_test();
  end
endmodule
